//--- hw/modem_ctrl_pkg.sv
package modem_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_ENH_FEATURE = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_LINE_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STAT = 3'h6;

  localparam logic [DATA_W-1:0] INT_ENABLE_RST = 8'h00;
  localparam logic [DATA_W-1:0] ENH_FEATURE_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODEM_CTRL_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MCR_TERM_READY = 0;
  localparam int MCR_SEND_REQ = 1;
  localparam int MCR_LOOPBACK = 4;
  localparam int MCR_INFRARED = 5;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_MODEM = 3;
  localparam int LSR_RX_PEND = 0;
  localparam int LSR_TX_PEND = 5;
  // Change flags sit in bits 3:0, current levels in bits 7:4.
  localparam int MSR_D_CTS = 0;
  localparam int MSR_D_DSR = 1;
  localparam int MSR_RI_RISE = 2;
  localparam int MSR_D_CD = 3;
  localparam int MSR_LVL_LSB = 4;

  // Synchronised pin vector: cts, dsr, ri, cd, rx.
  localparam int PIN_W = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h1f;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int REF_DIV = 3;
  localparam logic [1:0] REF_LAST = 2'(REF_DIV - 1);
  localparam int TX_INT_MAX_NS = 100;
  localparam int TX_INT_MAX_CYC = TX_INT_MAX_NS / CLK_PERIOD_NS;
  localparam int MSR_CLR_MAX_NS = 35;
  localparam int MSR_CLR_MAX_CYC = MSR_CLR_MAX_NS / CLK_PERIOD_NS;
  localparam int TX_START_MIN_RCLK = 8;
  localparam int TX_START_MAX_RCLK = 24;
  localparam logic [4:0] TX_START_RCLK = 5'((TX_START_MIN_RCLK + TX_START_MAX_RCLK) / 2);

  typedef enum logic [0:0] {TXS_IDLE, TXS_WAIT} tx_start_state_t;

endpackage

//--- hw/pin_sync3.sv
// Three-stage synchroniser with agreement filter: the level moves only
// once stages two and three agree, so a single-cycle glitch is dropped.
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [W-1:0] i_async, // Pins from outside
  output logic [W-1:0] o_level // Filtered level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      o_level <= RST;
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_level <= (s2_q & s3_q) | (o_level & (s2_q ^ s3_q));
    end
  end

endmodule

//--- hw/modem_signal_ctrl.sv
// How it works
// - Terminal-ready pin is inverse of control bit 0.
// - Set-ready, carrier, ring: status only.
// - Control bit 1 set drives send-request low.
// - Send-request pin high after reset.
// - Auto flow: send-request low asks send, high suspends.
// - Clear-to-send change sets flag 0, interrupt.
// - Auto flow: clear-to-send high holds transmitter.
// - Set-ready change sets flag 1, interrupt.
// - Carrier change sets flag 3, interrupt.
// - Only ring rising edge sets flag 2.
// - Transmit pin rests high in normal mode.
// - Loopback: pin high, receive ignored, internal route.
// - Infrared mode: transmit pin rests low.
// - Receive interrupt within one reference cycle.
// - Transmit interrupt within 100 ns of stop.
// - Next character starts 8 to 24 reference cycles.
// - Status read clears modem interrupt within 35 ns.
// - Reset forces internal receive and transmit high.
// - Reference clock is crystal divided by three.
module modem_signal_ctrl
  import modem_ctrl_pkg::*;
(
  input wire logic i_clk, // Crystal clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] i_addr, // Register address
  input wire logic [DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [DATA_W-1:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_clear_to_send_in_n, // Clear-to-send pin
  input wire logic i_set_ready_in_n, // Data-set-ready pin
  input wire logic i_carrier_detect_in_n, // Carrier-detect pin
  input wire logic i_ring_indicator_in_n, // Ring-indicator pin
  input wire logic i_serial_rx_in, // Receive pin
  output logic o_terminal_ready_out_n, // Terminal-ready pin
  output logic o_send_request_out_n, // Send-request pin
  output logic o_serial_tx_out, // Transmit pin
  input wire logic i_tx_bit, // Serial bit from transmitter core
  input wire logic i_tx_busy, // Transmitter is shifting a character
  input wire logic i_tx_enable, // Transmitter enabled
  input wire logic i_sleep, // Sleep mode
  input wire logic i_rx_room, // Receive buffer below threshold
  input wire logic i_rx_stop_sampled, // Receiver sampled a stop bit
  input wire logic i_tx_stop_done, // Transmitter finished a stop bit
  output logic o_rx_bit, // Serial bit into receiver core
  output logic o_tx_hold, // Suspend transmission
  output logic o_tx_start, // Start next character
  output logic o_ref_tick, // Reference-clock enable
  output logic o_irq // Interrupt request
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle is kept.
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  logic [DATA_W-1:0] ier_q;
  logic [DATA_W-1:0] efr_q;
  logic [DATA_W-1:0] mcr_q;
  logic [3:0] delta_q;
  logic [3:0] delta_set;
  logic rx_int_q;
  logic tx_int_q;
  logic [1:0] ref_cnt_q;
  logic [4:0] start_cnt_q;
  tx_start_state_t start_st_q;
  logic [PIN_W-1:0] pin_lvl;
  logic [3:0] lvl_q;
  logic [3:0] lvl_now;
  logic rx_sync;
  logic wr_hold;
  logic rd_msr;
  logic rd_hold;
  logic msr_pend;
  logic tx_idle_level;

  assign wr_hold = i_wr && (i_addr == OFS_TX_HOLD);
  assign rd_msr = i_rd && (i_addr == OFS_MODEM_STAT);
  assign rd_hold = i_rd && (i_addr == OFS_TX_HOLD);

  // ---------------------------------------------------------------------------
  // Reference clock
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ref_cnt_q <= 2'h0;
    else if (ref_cnt_q == REF_LAST)
      ref_cnt_q <= 2'h0;
    else
      ref_cnt_q <= ref_cnt_q + 2'h1;
  end

  assign o_ref_tick = (ref_cnt_q == REF_LAST);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ier_q <= INT_ENABLE_RST;
      efr_q <= ENH_FEATURE_RST;
      mcr_q <= MODEM_CTRL_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == OFS_INT_ENABLE)
        ier_q <= i_wdata;
      if (i_addr == OFS_ENH_FEATURE)
        efr_q <= i_wdata;
      if (i_addr == OFS_MODEM_CTRL)
        mcr_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        OFS_INT_ENABLE: o_rdata <= ier_q;
        OFS_ENH_FEATURE: o_rdata <= efr_q;
        OFS_MODEM_CTRL: o_rdata <= mcr_q;
        OFS_LINE_STAT:
        begin
          o_rdata <= 8'h00;
          o_rdata[LSR_RX_PEND] <= rx_int_q;
          o_rdata[LSR_TX_PEND] <= tx_int_q;
        end
        OFS_MODEM_STAT: o_rdata <= {lvl_q, delta_q};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------------------
  // Modem pins
  // ---------------------------------------------------------------------------
  pin_sync3 #(
    .W(PIN_W),
    .RST(PIN_RST)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_serial_rx_in, i_carrier_detect_in_n, i_ring_indicator_in_n,
              i_set_ready_in_n, i_clear_to_send_in_n}),
    .o_level(pin_lvl)
  );

  // Active-high levels in change-flag order: cts, dsr, ri, cd.
  assign lvl_now = ~pin_lvl[3:0];
  assign rx_sync = pin_lvl[4];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      lvl_q <= 4'h0;
    else
      lvl_q <= lvl_now;
  end

  always_comb
  begin
    delta_set = lvl_now ^ lvl_q;
    delta_set[MSR_RI_RISE] = ~lvl_now[MSR_RI_RISE] & lvl_q[MSR_RI_RISE];
  end

  // Ring is active low on the pin, so its low-to-high pin edge is the
  // moment the active-high level falls.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      delta_q <= 4'h0;
    else
      for (int i = 0; i < 4; i++)
        delta_q[i] <= flag_next(delta_q[i], delta_set[i], rd_msr);
  end

  assign msr_pend = |delta_q;

  // The set-ready, carrier and ring levels feed only the status register.
  assign o_terminal_ready_out_n = ~mcr_q[MCR_TERM_READY];

  // Automatic mode still needs the software bit, so software must raise it
  // after enabling automatic flow.
  assign o_send_request_out_n = efr_q[EFR_AUTO_RTS] ?
                                ~(mcr_q[MCR_SEND_REQ] & i_rx_room) :
                                ~mcr_q[MCR_SEND_REQ];

  assign o_tx_hold = efr_q[EFR_AUTO_CTS] & ~lvl_now[MSR_D_CTS];

  // ---------------------------------------------------------------------------
  // Serial line
  // ---------------------------------------------------------------------------
  always_comb
  begin
    tx_idle_level = ~mcr_q[MCR_INFRARED];
    if (mcr_q[MCR_LOOPBACK])
      tx_idle_level = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_serial_tx_out <= 1'b1;
      o_rx_bit <= 1'b1;
    end
    else
    begin
      if (mcr_q[MCR_LOOPBACK] || !i_tx_busy || !i_tx_enable || i_sleep)
        o_serial_tx_out <= tx_idle_level;
      else if (mcr_q[MCR_INFRARED])
        o_serial_tx_out <= ~i_tx_bit;
      else
        o_serial_tx_out <= i_tx_bit;
      if (mcr_q[MCR_LOOPBACK])
        o_rx_bit <= i_tx_bit;
      else if (mcr_q[MCR_INFRARED])
        o_rx_bit <= ~rx_sync;
      else
        o_rx_bit <= rx_sync;
    end
  end

  // ---------------------------------------------------------------------------
  // Character interrupts and transmit start
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rx_int_q <= 1'b0;
      tx_int_q <= 1'b0;
    end
    else
    begin
      rx_int_q <= flag_next(rx_int_q, i_rx_stop_sampled, rd_hold);
      tx_int_q <= flag_next(tx_int_q, i_tx_stop_done, wr_hold);
    end
  end

  // The delay is counted in reference ticks so it scales with the divider.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      start_st_q <= TXS_IDLE;
      start_cnt_q <= 5'h00;
      o_tx_start <= 1'b0;
    end
    else
    begin
      o_tx_start <= 1'b0;
      case (start_st_q)
        TXS_IDLE:
          if (wr_hold)
          begin
            start_st_q <= TXS_WAIT;
            start_cnt_q <= 5'h00;
          end
        TXS_WAIT:
          if (o_ref_tick)
          begin
            if (start_cnt_q == TX_START_RCLK - 5'h01)
            begin
              o_tx_start <= 1'b1;
              start_st_q <= TXS_IDLE;
            end
            else
              start_cnt_q <= start_cnt_q + 5'h01;
          end
        default: start_st_q <= TXS_IDLE;
      endcase
    end
  end

  assign o_irq = (msr_pend & ier_q[IER_MODEM]) |
                 (rx_int_q & ier_q[IER_RX]) |
                 (tx_int_q & ier_q[IER_TX]);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  localparam int start_lo_c = TX_START_MIN_RCLK * REF_DIV;
  localparam int start_hi_c = TX_START_MAX_RCLK * REF_DIV;
  localparam int msr_clr_c = MSR_CLR_MAX_CYC;
  localparam int tx_int_c = TX_INT_MAX_CYC;

  // Clocks since the write that armed the start timer, so the window can be checked.
  logic [6:0] start_age_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      start_age_q <= 7'h00;
    else if (wr_hold && start_st_q == TXS_IDLE)
      start_age_q <= 7'h01;
    else if (start_st_q == TXS_WAIT)
      start_age_q <= start_age_q + 7'h01;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  term_ready_wr_a: assert property ((i_wr && i_addr == OFS_MODEM_CTRL) |=>
    o_terminal_ready_out_n == !$past(i_wdata[MCR_TERM_READY]))
    else $error("terminal ready pin does not follow control bit 0");
  send_req_reset_a: assert property ($past(i_rst) |-> o_send_request_out_n)
    else $error("send request not high after reset");
  send_req_wr_a: assert property ((i_wr && i_addr == OFS_MODEM_CTRL &&
    i_wdata[MCR_SEND_REQ] && !efr_q[EFR_AUTO_RTS]) |=> !o_send_request_out_n)
    else $error("send request not driven low");
  auto_rts_a: assert property ((efr_q[EFR_AUTO_RTS] && !i_rx_room) |->
    o_send_request_out_n)
    else $error("auto flow did not suspend remote");
  auto_cts_a: assert property ((efr_q[EFR_AUTO_CTS] && pin_lvl[0]) |->
    o_tx_hold)
    else $error("transmitter not held while clear to send high");
  cts_flag_a: assert property (($changed(lvl_now[MSR_D_CTS]) && !rd_msr) |=>
    delta_q[MSR_D_CTS] && o_irq == ier_q[IER_MODEM] || rx_int_q || tx_int_q)
    else $error("clear to send change not flagged");
  ring_fall_a: assert property ((!delta_q[MSR_RI_RISE] && $rose(lvl_now[MSR_RI_RISE])) |=>
    !delta_q[MSR_RI_RISE])
    else $error("ring falling pin edge set a flag");
  ring_rise_a: assert property ($fell(lvl_now[MSR_RI_RISE]) |=> delta_q[MSR_RI_RISE])
    else $error("ring rising pin edge not flagged");
  msr_clear_a: assert property ((rd_msr && delta_set == 4'h0) |->
    ##[1:msr_clr_c] !msr_pend)
    else $error("status read did not clear modem interrupt");
  loop_tx_a: assert property (mcr_q[MCR_LOOPBACK] |=> o_serial_tx_out)
    else $error("transmit pin not high in loopback");
  rx_int_a: assert property (i_rx_stop_sampled |=> rx_int_q)
    else $error("receive interrupt late");
  tx_int_a: assert property (i_tx_stop_done |-> ##[1:tx_int_c] tx_int_q)
    else $error("transmit interrupt late");
  tx_start_a: assert property ((wr_hold && start_st_q == TXS_IDLE) |->
    ##[1:start_hi_c] o_tx_start)
    else $error("transmit start missing after hold write");
  tx_start_early_a: assert property (o_tx_start |->
    (start_age_q >= 7'(start_lo_c) && start_age_q <= 7'(start_hi_c)))
    else $error("transmit start outside its window");
  irq_mask_a: assert property ((ier_q == 8'h00) |-> !o_irq)
    else $error("interrupt raised while disabled");

  ring_seen_c: cover property ($fell(lvl_now[MSR_RI_RISE]) ##1 rd_msr);
  tx_start_c: cover property (wr_hold ##[1:start_hi_c] o_tx_start);
  loop_c: cover property (mcr_q[MCR_LOOPBACK] && i_tx_busy && !i_tx_bit);
  auto_rts_c: cover property (efr_q[EFR_AUTO_RTS] && mcr_q[MCR_SEND_REQ] && $fell(i_rx_room));

endmodule

//--- bench/modem_line_model.sv
// -----------------------------------------------------------------------------
// Far-side modem and line driver
// -----------------------------------------------------------------------------
// Status pins follow the requested levels at once, or two clocks late in
// slow mode, so the pin synchroniser also sees changes that arrive late.
module modem_line_model (
  input wire logic i_clk, // Clock
  input wire logic [3:0] i_want_n, // Requested levels: cts, dsr, ring, carrier
  input wire logic i_slow, // Answer two clocks late
  input wire logic i_infrared, // Line is an infrared link
  output logic o_clear_to_send_in_n, // Clear-to-send pin
  output logic o_set_ready_in_n, // Data-set-ready pin
  output logic o_ring_indicator_in_n, // Ring-indicator pin
  output logic o_carrier_detect_in_n, // Carrier-detect pin
  output logic o_serial_rx_in // Receive pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lag1_q = 4'hf;
  logic [3:0] lag2_q = 4'hf;
  logic [3:0] pins;

  always @(posedge i_clk)
  begin
    lag1_q <= i_want_n;
    lag2_q <= lag1_q;
  end
  assign pins = i_slow ? lag2_q : i_want_n;
  assign o_clear_to_send_in_n = pins[0];
  assign o_set_ready_in_n = pins[1];
  assign o_ring_indicator_in_n = pins[2];
  assign o_carrier_detect_in_n = pins[3];
  // The receive line rests high on a wire link and low on an infrared one.
  assign o_serial_rx_in = ~i_infrared;
endmodule

//--- bench/uart_modem_signal_control_tb.sv
module uart_modem_signal_control_tb;
  import modem_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] modem_control_reg; logic tr; logic sr; logic tx;} row_t;
  localparam row_t ROWS [6] = '{'{8'h00, 1'b1, 1'b1, 1'b1}, '{8'h01, 1'b0, 1'b1, 1'b1},
    '{8'h02, 1'b1, 1'b0, 1'b1}, '{8'h10, 1'b1, 1'b1, 1'b1}, '{8'h20, 1'b1, 1'b1, 1'b0},
    '{8'h30, 1'b1, 1'b1, 1'b1}};
  localparam int PINS [3] = '{0, 1, 3};
  logic i_clk = 1'b0;
  logic i_rst, i_wr, i_rd, tx_bit, tx_busy, tx_enable, sleep, rx_room, rx_stop, tx_stop;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [3:0] want_n;
  logic slow, infra, cts_n, dsr_n, ri_n, cd_n, rx_pin;
  logic tr_n, sr_n, tx_out, rx_bit, tx_hold, tx_start, ref_tick, o_irq;
  int n_mismatch = 0;
  int checked = 0;
  int n;

  always #2.5 i_clk = ~i_clk;

  modem_line_model modem_line_model_inst (.i_clk(i_clk), .i_want_n(want_n), .i_slow(slow),
    .i_infrared(infra), .o_clear_to_send_in_n(cts_n), .o_set_ready_in_n(dsr_n),
    .o_ring_indicator_in_n(ri_n), .o_carrier_detect_in_n(cd_n), .o_serial_rx_in(rx_pin));

  modem_signal_ctrl modem_signal_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_clear_to_send_in_n(cts_n), .i_set_ready_in_n(dsr_n), .i_carrier_detect_in_n(cd_n),
    .i_ring_indicator_in_n(ri_n), .i_serial_rx_in(rx_pin), .o_terminal_ready_out_n(tr_n),
    .o_send_request_out_n(sr_n), .o_serial_tx_out(tx_out), .i_tx_bit(tx_bit),
    .i_tx_busy(tx_busy), .i_tx_enable(tx_enable), .i_sleep(sleep), .i_rx_room(rx_room),
    .i_rx_stop_sampled(rx_stop), .i_tx_stop_done(tx_stop), .o_rx_bit(rx_bit),
    .o_tx_hold(tx_hold), .o_tx_start(tx_start), .o_ref_tick(ref_tick), .o_irq(o_irq));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each bus task waits an edge first, so two calls never drive a strobe twice at once.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_irq(input logic v, input int lim);
    int k;
    k = 0;
    while (o_irq !== v && k < lim)
    begin
      @(posedge i_clk);
      #1 k++;
    end
    if (o_irq !== v)
    begin
      chk("irq_wait", 8'(o_irq), 8'(v));
      summarize();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 13'h0};
    {want_n, slow, infra, tx_bit, tx_busy, tx_enable} = {4'hf, 1'b0, 1'b1, 3'b101};
    {sleep, rx_room, rx_stop, tx_stop} = 4'b0100;
    settle(8);
    chk("send_request_reset", 8'(sr_n), 8'h1);
    chk("tx_reset", 8'(tx_out), 8'h1);
    chk("rx_forced_reset", 8'(rx_bit), 8'h1);
    @(posedge i_clk);
    i_rst <= 1'b0;
    infra <= 1'b0;
    $display("test reset done");
    foreach (ROWS[k])
    begin
      wr(OFS_MODEM_CTRL, ROWS[k].modem_control_reg);
      settle(2);
      chk("terminal_ready", 8'(tr_n), 8'(ROWS[k].tr));
      chk("send_request", 8'(sr_n), 8'(ROWS[k].sr));
      chk("tx_idle", 8'(tx_out), 8'(ROWS[k].tx));
    end
    $display("test control rows done");
    wr(OFS_MODEM_CTRL, 8'h10);
    tx_busy <= 1'b1;
    tx_bit <= 1'b0;
    settle(3);
    chk("tx_loopback", 8'(tx_out), 8'h1);
    chk("rx_loopback", 8'(rx_bit), 8'h0);
    wr(OFS_MODEM_CTRL, 8'h01);
    settle(3);
    chk("tx_data", 8'(tx_out), 8'h0);
    chk("rx_pin", 8'(rx_bit), 8'h1);
    sleep <= 1'b1;
    settle(3);
    chk("tx_sleep", 8'(tx_out), 8'h1);
    {sleep, tx_enable} <= 2'b00;
    settle(3);
    chk("tx_disabled", 8'(tx_out), 8'h1);
    {tx_enable, tx_busy} <= 2'b10;
    $display("test serial lines done");
    wr(OFS_ENH_FEATURE, 8'h40);
    wr(OFS_MODEM_CTRL, 8'h02);
    settle(2);
    chk("auto_send_request_on", 8'(sr_n), 8'h0);
    rx_room <= 1'b0;
    settle(2);
    chk("auto_send_request_off", 8'(sr_n), 8'h1);
    wr(OFS_ENH_FEATURE, 8'h80);
    settle(8);
    chk("tx_hold_on", 8'(tx_hold), 8'h1);
    want_n[0] <= 1'b0;
    settle(8);
    chk("tx_hold_off", 8'(tx_hold), 8'h0);
    want_n[0] <= 1'b1;
    wr(OFS_ENH_FEATURE, 8'h00);
    settle(8);
    rd(OFS_MODEM_STAT, d);
    $display("test flow control done");
    wr(OFS_INT_ENABLE, 8'h08);
    foreach (PINS[k])
    begin
      @(posedge i_clk);
      slow <= (PINS[k] == 3);
      want_n[PINS[k]] <= 1'b0;
      wait_irq(1'b1, 20);
      rd(OFS_MODEM_STAT, d);
      chk("status_change", d, 8'h11 << PINS[k]);
      chk("irq_after_read", 8'(o_irq), 8'h0);
      @(posedge i_clk);
      want_n[PINS[k]] <= 1'b1;
      wait_irq(1'b1, 20);
      rd(OFS_MODEM_STAT, d);
      chk("status_restore", d, 8'h01 << PINS[k]);
    end
    @(posedge i_clk);
    want_n[2] <= 1'b0;
    settle(10);
    chk("ring_fall_irq", 8'(o_irq), 8'h0);
    rd(OFS_MODEM_STAT, d);
    chk("ring_fall_status", d, 8'h40);
    @(posedge i_clk);
    want_n[2] <= 1'b1;
    wait_irq(1'b1, 20);
    rd(OFS_MODEM_STAT, d);
    chk("ring_rise_status", d, 8'h04);
    wr(OFS_INT_ENABLE, 8'h00);
    want_n[3] <= 1'b0;
    settle(10);
    chk("masked_irq", 8'(o_irq), 8'h0);
    rd(OFS_MODEM_STAT, d);
    chk("masked_status", d, 8'h88);
    want_n[3] <= 1'b1;
    settle(10);
    rd(OFS_MODEM_STAT, d);
    $display("test modem status done");
    wr(OFS_INT_ENABLE, 8'h03);
    rx_stop <= 1'b1;
    @(posedge i_clk);
    rx_stop <= 1'b0;
    #1 chk("rx_irq", 8'(o_irq), 8'h1);
    rd(OFS_LINE_STAT, d);
    chk("rx_pending", d, 8'h01);
    rd(OFS_TX_HOLD, d);
    chk("rx_irq_cleared", 8'(o_irq), 8'h0);
    @(posedge i_clk);
    tx_stop <= 1'b1;
    @(posedge i_clk);
    tx_stop <= 1'b0;
    wait_irq(1'b1, TX_INT_MAX_CYC);
    rd(OFS_LINE_STAT, d);
    chk("tx_pending", d, 8'h20);
    wr(OFS_TX_HOLD, 8'h55);
    #1 n = 1;
    while (tx_start !== 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("tx_start_window", 8'(n >= 24 && n <= 72), 8'h1);
    if (n == 100)
    begin
      summarize();
    end
    $display("test character events done");
    n = 0;
    repeat (30)
    begin
      @(posedge i_clk);
      #1 n += (ref_tick === 1'b1);
    end
    chk("ref_ticks", 8'(n), 8'd10);
    rd(3'h3, d);
    chk("unmapped_read", d, 8'h00);
    $display("test misc done");
    summarize();
  end
endmodule
